// file: verilog/txb_pkg.sv
// Purpose: shared constants and types for the transmit buffer selection arbiter
// Assumes: one clock (mclk, 25 MHz), synchronous active-high reset
// Notes: eight single transmit buffers, two channels
package txb_pkg;
	localparam int NBUF = 8;
	localparam int BW = 3;
	localparam int IDW = 11;
	localparam int MTW = 16;
	localparam int DW = 16;
	// host command codes
	typedef enum logic [2:0] {
		TXB_OP_NONE,
		TXB_OP_CONFIG,
		TXB_OP_LOCK,
		TXB_OP_UNLOCK,
		TXB_OP_WRITE,
		TXB_OP_COMMIT,
		TXB_OP_CLRFLAG,
		TXB_OP_GLOBAL
	} txb_op_type;
	// config word field positions
	localparam int CFG_TX_BIT = 31;
	localparam int CFG_BTYPE_BIT = 30;
	localparam int CFG_DYN_BIT = 29;
	localparam int CFG_CHB_BIT = 28;
	localparam int CFG_CHA_BIT = 27;
	localparam int CFG_TMODE_BIT = 26;
	localparam int CFG_IEN_BIT = 25;
	localparam int CFG_ID_LSB = 0;
	// global word: bit 31 selects sync frame reg, else idle time config reg
	localparam int GLB_SEL_BIT = 31;
	// payload words needed to carry the whole message identifier
	localparam logic [6:0] MSGID_MIN_LEN = 7'h01;
	localparam logic [15:0] MSGID_DEFAULT = 16'h0000;
	// commit deadline before slot n-1, in microticks
	localparam logic [15:0] COMMIT_LEAD_UT = 16'h0004;
	// reset values
	localparam logic [MTW-1:0] IDLE_RESET = 16'hffff;
	localparam logic [IDW-1:0] SYNC_RESET = 11'h000;
	// host register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_GLOBAL = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CMD_OP_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage // txb_pkg

// file: verilog/txb_if.sv
// Purpose: link between host end and controller end
// Assumes: both ends on mclk
// Notes: one command in flight, done pulse answers it
interface txb_if;
	import txb_pkg::*;
	logic cmd_valid;
	txb_op_type cmd_op;
	logic [BW-1:0] cmd_buf;
	logic [31:0] cmd_data;
	logic cmd_done;
	logic cmd_ok;
	logic [NBUF-1:0] stat_lock;
	logic [NBUF-1:0] stat_commit;
	logic [NBUF-1:0] stat_valid;
	logic [NBUF-1:0] stat_event;
	logic [DW-1:0] rd_data;
	logic irq;
	logic tx_enable;
	modport host (output cmd_valid, cmd_op, cmd_buf, cmd_data,
		input cmd_done, cmd_ok, stat_lock, stat_commit, stat_valid, stat_event, rd_data, irq, tx_enable);
	modport dev (input cmd_valid, cmd_op, cmd_buf, cmd_data,
		output cmd_done, cmd_ok, stat_lock, stat_commit, stat_valid, stat_event, rd_data, irq, tx_enable);
endinterface // txb_if

// file: verilog/txb_dev.sv
// Purpose: controller end: transmit buffer store, slot selection, flag update
// Assumes: slot pulses, frame done pulses and macrotick count come from protocol logic on mclk
// Notes: Operation list below
// Operation
// - short payload filters with default identifier zero
// - send only configured, committed transmit buffers
// - host commits then unlocks; valid keeps eligibility
// - host configures, locks, writes, commits, unlocks
// - host commits four microticks before slot n-1; a later commit or unlock is still issued and only sets late_r
// - static slot picks buffers matching next slot
// - never send buffer whose valid is clear
// - static ties go to lowest buffer index
// - same static slot, both channels sent together
// - unlock validates commit; lock refused until sent
// - after send: event set, commit cleared, valid per mode
// - dynamic picks lowest pending identifier
// - independent dynamic minislot sequence per channel
// - no dynamic frame overlapping network idle period
// - dynamic ties: lowest index, others excluded this cycle
// - host gives dynamic ids above static ids
// - no null frames in dynamic segment
// - same dynamic slot, both channels same minislot
// - transmit only with a buffer or sync frame
// - host clears buffer type bit for single
// - host waits for lock readback before writing
// - masked buffer events ORed onto interrupt
module txb_dev
	import txb_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// host link
	txb_if.dev hl,
	// slot timing, one pulse per slot per channel
	input wire logic [1:0] slot_go,
	input wire logic [2*IDW-1:0] slot_id,
	input wire logic seg_dyn,
	input wire logic cycle_start,
	input wire logic [MTW-1:0] mt_now,
	input wire logic [MTW-1:0] frame_mt,
	// per channel frame completion
	input wire logic [1:0] tx_done,
	// per channel transmit start
	output logic [1:0] tx_go,
	output logic [2*BW-1:0] tx_buf,
	output logic [2*IDW-1:0] tx_id,
	output logic [2*DW-1:0] tx_data,
	// receive filter front end
	input wire logic rx_valid,
	input wire logic [6:0] rx_len,
	input wire logic [15:0] rx_msg_id,
	output logic rx_filt_valid,
	output logic [15:0] rx_filt_id
);
	logic [NBUF-1:0] cfg_tx_r, btype_r, dyn_r, cha_r, chb_r, tmode_r, ien_r;
	logic [NBUF-1:0] commit_r, valid_r, event_r, lock_r, excl_r;
	logic [IDW-1:0] id_r [NBUF];
	logic [DW-1:0] data_r [NBUF];
	logic [MTW-1:0] idle_r;
	logic [IDW-1:0] sync_r;
	logic [BW-1:0] pend_r [2];
	logic [1:0] pend_v_r;
	logic [1:0] sel_v;
	logic [BW-1:0] sel_idx [2];
	logic [NBUF-1:0] sel_excl [2];
	logic [NBUF-1:0] sent;
	logic [NBUF-1:0] do_excl;
	logic fits_idle;
	logic cmd_ok_nxt;
	// a dynamic segment frame that would run into the idle period is held back
	assign fits_idle = ({1'b0, mt_now} + {1'b0, frame_mt}) <= {1'b0, idle_r};
	// per channel search, lowest index first; the two channels run on their own slot ids
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			sel_v[c] = 1'b0;
			sel_idx[c] = '0;
			sel_excl[c] = '0;
			for (int b = NBUF - 1; b >= 0; b--)
			begin
				if (cfg_tx_r[b] && commit_r[b] && valid_r[b] && !lock_r[b] && !btype_r[b]
					&& (c == 0 ? cha_r[b] : chb_r[b])
					&& id_r[b] == slot_id[c*IDW +: IDW]
					&& dyn_r[b] == seg_dyn
					&& !(seg_dyn && excl_r[b]))
				begin
					if (sel_v[c])
						sel_excl[c][sel_idx[c]] = 1'b1;
					sel_v[c] = 1'b1;
					sel_idx[c] = BW'(b);
				end
			end
		end
	end
	// start frames; both channels act in the same cycle for a shared slot
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			tx_go <= '0;
			pend_v_r <= '0;
			pend_r[0] <= '0;
			pend_r[1] <= '0;
			tx_buf <= '0;
			tx_id <= '0;
			tx_data <= '0;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				// no candidate means no frame at all in the dynamic part, never a null one
				tx_go[c] <= slot_go[c] && sel_v[c] && hl.tx_enable && (!seg_dyn || fits_idle);
				if (slot_go[c] && sel_v[c] && hl.tx_enable && (!seg_dyn || fits_idle))
				begin
					pend_v_r[c] <= 1'b1;
					pend_r[c] <= sel_idx[c];
					tx_buf[c*BW +: BW] <= sel_idx[c];
					tx_id[c*IDW +: IDW] <= id_r[sel_idx[c]];
					tx_data[c*DW +: DW] <= data_r[sel_idx[c]];
				end
				else if (tx_done[c])
					pend_v_r[c] <= 1'b0;
			end
		end
	end
	// global registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			idle_r <= IDLE_RESET;
			sync_r <= SYNC_RESET;
		end
		else if (hl.cmd_valid && hl.cmd_op == TXB_OP_GLOBAL)
		begin
			if (hl.cmd_data[GLB_SEL_BIT])
				sync_r <= hl.cmd_data[IDW-1:0];
			else
				idle_r <= hl.cmd_data[MTW-1:0];
		end
	end
	// per buffer state
	generate
		for (genvar b = 0; b < NBUF; b++)
		begin : g_buf
			logic me;
			assign me = hl.cmd_valid && hl.cmd_buf == BW'(b);
			assign sent[b] = (tx_done[0] && pend_v_r[0] && pend_r[0] == BW'(b))
				|| (tx_done[1] && pend_v_r[1] && pend_r[1] == BW'(b));
			assign do_excl[b] = seg_dyn && ((slot_go[0] && sel_excl[0][b]) || (slot_go[1] && sel_excl[1][b]));
			always_ff @(posedge mclk)
			begin
				if (reset)
				begin
					{cfg_tx_r[b], btype_r[b], dyn_r[b], cha_r[b], chb_r[b], tmode_r[b], ien_r[b]} <= '0;
					id_r[b] <= '0;
					data_r[b] <= '0;
				end
				else if (me && hl.cmd_op == TXB_OP_CONFIG && !lock_r[b] && !valid_r[b])
				begin
					cfg_tx_r[b] <= hl.cmd_data[CFG_TX_BIT];
					btype_r[b] <= hl.cmd_data[CFG_BTYPE_BIT];
					dyn_r[b] <= hl.cmd_data[CFG_DYN_BIT];
					cha_r[b] <= hl.cmd_data[CFG_CHA_BIT];
					chb_r[b] <= hl.cmd_data[CFG_CHB_BIT];
					tmode_r[b] <= hl.cmd_data[CFG_TMODE_BIT];
					ien_r[b] <= hl.cmd_data[CFG_IEN_BIT];
					id_r[b] <= hl.cmd_data[CFG_ID_LSB +: IDW];
				end
				else if (me && hl.cmd_op == TXB_OP_WRITE && lock_r[b])
					data_r[b] <= hl.cmd_data[DW-1:0];
			end
			always_ff @(posedge mclk)
			begin
				if (reset)
				begin
					commit_r[b] <= 1'b0;
					valid_r[b] <= 1'b0;
					lock_r[b] <= 1'b0;
				end
				else if (sent[b])
				begin
					commit_r[b] <= 1'b0;
					valid_r[b] <= tmode_r[b];
				end
				else if (me)
				begin
					// a waiting committed buffer cannot be taken back by the host
					if (hl.cmd_op == TXB_OP_LOCK && !(commit_r[b] && valid_r[b]))
						lock_r[b] <= 1'b1;
					if (hl.cmd_op == TXB_OP_UNLOCK && lock_r[b])
					begin
						lock_r[b] <= 1'b0;
						if (commit_r[b])
							valid_r[b] <= 1'b1;
					end
					if (hl.cmd_op == TXB_OP_COMMIT && lock_r[b])
						commit_r[b] <= 1'b1;
				end
			end
			// set wins over a clear in the same cycle
			always_ff @(posedge mclk)
			begin
				if (reset)
					event_r[b] <= 1'b0;
				else if (sent[b])
					event_r[b] <= 1'b1;
				else if (me && hl.cmd_op == TXB_OP_CLRFLAG)
					event_r[b] <= 1'b0;
			end
			always_ff @(posedge mclk)
			begin
				if (reset || cycle_start)
					excl_r[b] <= 1'b0;
				else if (do_excl[b])
					excl_r[b] <= 1'b1;
			end
		end
	endgenerate
	always_comb
	begin
		cmd_ok_nxt = 1'b1;
		unique case (hl.cmd_op)
			TXB_OP_LOCK: cmd_ok_nxt = !(commit_r[hl.cmd_buf] && valid_r[hl.cmd_buf]);
			TXB_OP_WRITE, TXB_OP_COMMIT, TXB_OP_UNLOCK: cmd_ok_nxt = lock_r[hl.cmd_buf];
			TXB_OP_CONFIG: cmd_ok_nxt = !lock_r[hl.cmd_buf] && !valid_r[hl.cmd_buf];
			TXB_OP_NONE, TXB_OP_CLRFLAG, TXB_OP_GLOBAL: cmd_ok_nxt = 1'b1;
		endcase
	end
	// host facing status
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			hl.cmd_done <= 1'b0;
			hl.cmd_ok <= 1'b0;
			hl.rd_data <= '0;
			hl.irq <= 1'b0;
			hl.tx_enable <= 1'b0;
		end
		else
		begin
			hl.cmd_done <= hl.cmd_valid;
			hl.cmd_ok <= cmd_ok_nxt;
			hl.rd_data <= data_r[hl.cmd_buf];
			hl.irq <= |(event_r & ien_r);
			hl.tx_enable <= (|cfg_tx_r) || (sync_r != SYNC_RESET);
		end
	end
	assign hl.stat_lock = lock_r;
	assign hl.stat_commit = commit_r;
	assign hl.stat_valid = valid_r;
	assign hl.stat_event = event_r;
	// too short to carry the message id: filter on zero
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rx_filt_valid <= 1'b0;
			rx_filt_id <= MSGID_DEFAULT;
		end
		else
		begin
			rx_filt_valid <= rx_valid;
			rx_filt_id <= (rx_len < MSGID_MIN_LEN) ? MSGID_DEFAULT : rx_msg_id;
		end
	end
endmodule // txb_dev

// file: verilog/txb_host.sv
// Purpose: host end: AXI4-Lite registers turned into buffer commands
// Assumes: software drives the prepare sequence through REG_CMD
// Notes: one command at a time; bus write waits for the command answer
module txb_host
	import txb_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// controller link
	txb_if.host hl,
	// microticks left before slot n-1 or idle period
	input wire logic [15:0] ut_to_deadline,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic aw_have_r, w_have_r, busy_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, data_r;
	logic [BW-1:0] sel_r;
	logic refused_r, late_r;
	logic [IDW-1:0] max_static_r;
	txb_op_type op;
	logic [BW-1:0] cbuf;
	logic local_ok;

	assign op = txb_op_type'(wdata_r[CMD_OP_LSB +: 3]);
	assign cbuf = wdata_r[BW-1:0];
	// checks the host keeps before issuing a command
	always_comb
	begin
		local_ok = 1'b1;
		if ((op == TXB_OP_WRITE || op == TXB_OP_COMMIT) && !hl.stat_lock[cbuf])
			local_ok = 1'b0;
		if (op == TXB_OP_CONFIG && data_r[CFG_DYN_BIT] && data_r[IDW-1:0] <= max_static_r)
			local_ok = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
		end
		else
		begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
			end
		end
	end

	// write action: command waits for the controller answer before the response
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			busy_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			hl.cmd_valid <= 1'b0;
			hl.cmd_op <= TXB_OP_NONE;
			hl.cmd_buf <= '0;
			hl.cmd_data <= '0;
			data_r <= '0;
			sel_r <= '0;
			refused_r <= 1'b0;
			late_r <= 1'b0;
			max_static_r <= '0;
		end
		else
		begin
			hl.cmd_valid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			else if (aw_have_r && w_have_r && !busy_r && !s_axi_bvalid)
			begin
				s_axi_bresp <= RESP_OKAY;
				unique case (awaddr_r)
					REG_DATA:
					begin
						data_r <= wdata_r;
						s_axi_bvalid <= 1'b1;
					end
					REG_CMD:
					begin
						sel_r <= cbuf;
						if (local_ok)
						begin
							busy_r <= 1'b1;
							hl.cmd_valid <= 1'b1;
							hl.cmd_op <= op;
							hl.cmd_buf <= cbuf;
							// only single buffers exist here: type bit always cleared
							hl.cmd_data <= (op == TXB_OP_CONFIG) ? (data_r & ~(32'h0000_0001 << CFG_BTYPE_BIT)) : data_r;
							if (op == TXB_OP_CONFIG && !data_r[CFG_DYN_BIT] && data_r[IDW-1:0] > max_static_r)
								max_static_r <= data_r[IDW-1:0];
							if ((op == TXB_OP_COMMIT || op == TXB_OP_UNLOCK) && ut_to_deadline < COMMIT_LEAD_UT)
								late_r <= 1'b1;
						end
						else
						begin
							refused_r <= 1'b1;
							s_axi_bresp <= RESP_SLVERR;
							s_axi_bvalid <= 1'b1;
						end
					end
					REG_STATUS:
					begin
						refused_r <= refused_r & ~wdata_r[8];
						late_r <= late_r & ~wdata_r[9];
						s_axi_bvalid <= 1'b1;
					end
					default:
					begin
						s_axi_bresp <= RESP_SLVERR;
						s_axi_bvalid <= 1'b1;
					end
				endcase
			end
			else if (busy_r && hl.cmd_done)
			begin
				busy_r <= 1'b0;
				refused_r <= refused_r | !hl.cmd_ok;
				s_axi_bresp <= hl.cmd_ok ? RESP_OKAY : RESP_SLVERR;
				s_axi_bvalid <= 1'b1;
			end
		end
	end

	// reads answer one cycle after the address is taken
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				unique case (s_axi_araddr)
					REG_DATA: s_axi_rdata <= data_r;
					REG_CMD: s_axi_rdata <= {29'h0000_0000, sel_r};
					REG_STATUS: s_axi_rdata <= {22'h00_0000, late_r, refused_r, 4'h0, hl.stat_event[sel_r],
						hl.stat_valid[sel_r], hl.stat_commit[sel_r], hl.stat_lock[sel_r]};
					REG_GLOBAL: s_axi_rdata <= {30'h0000_0000, hl.tx_enable, hl.irq};
					REG_RDATA: s_axi_rdata <= {16'h0000, hl.rd_data};
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end
endmodule // txb_host

// file: tb/txb_chk.sv
// Purpose: assertions on the link between host end and controller end
// Assumes: one clock, synchronous active-high reset
// Notes: flag rules are checked per buffer
module txb_chk
	import txb_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// command link
	input wire logic cmd_valid,
	input wire txb_op_type cmd_op,
	input wire logic [BW-1:0] cmd_buf,
	input wire logic cmd_done,
	input wire logic cmd_ok,
	// buffer flags
	input wire logic [NBUF-1:0] stat_lock,
	input wire logic [NBUF-1:0] stat_commit,
	input wire logic [NBUF-1:0] stat_valid,
	input wire logic [NBUF-1:0] stat_event,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	cmd_answer_a: assert property (cmd_valid |=> cmd_done) else $error("command not answered");
	irq_cause_a: assert property (irq |-> $past(stat_event) != '0) else $error("interrupt without event");
	irq_quiet_a: assert property ($past(stat_event) == '0 |-> !irq) else $error("interrupt while quiet");
	for (genvar i = 0; i < NBUF; i++)
	begin : g_buf
		lock_refuse_a: assert property (cmd_valid && cmd_op == TXB_OP_LOCK && cmd_buf == i
			&& stat_commit[i] && stat_valid[i] |=> cmd_done && !cmd_ok) else $error("pending buffer locked");
		cfg_refuse_a: assert property (cmd_valid && cmd_op == TXB_OP_CONFIG && cmd_buf == i
			&& (stat_lock[i] || stat_valid[i]) |=> !cmd_ok) else $error("busy buffer reconfigured");
		unlock_valid_a: assert property (cmd_valid && cmd_op == TXB_OP_UNLOCK && cmd_buf == i
			&& stat_lock[i] && stat_commit[i] |=> ##[0:1] stat_valid[i]) else $error("unlock left buffer invalid");
		event_sent_a: assert property ($rose(stat_event[i]) |-> $past(stat_commit[i]) && !stat_commit[i])
			else $error("event without commit clear");
		event_valid_a: assert property ($rose(stat_event[i]) |-> $past(stat_valid[i]))
			else $error("sent from invalid buffer");
		commit_fall_a: assert property ($fell(stat_commit[i]) |-> stat_event[i])
			else $error("commit dropped without send");
		valid_fall_a: assert property ($fell(stat_valid[i]) |-> stat_event[i])
			else $error("valid dropped without send");
	end
endmodule // txb_chk

// file: tb/tb_tx_buffer_selection_arbiter.sv
// Purpose: end to end test of host end and controller end
// Assumes: mclk 25 MHz, reset held 12 cycles
// Notes: flags are watched on the link; commands go over axi4-lite
module tb_tx_buffer_selection_arbiter
	import txb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic seg_dyn = 1'b0, cycle_start = 1'b0, rx_valid = 1'b0, rx_filt_valid;
	logic [1:0] slot_go = '0, tx_done = '0, tx_go, bresp, rresp;
	logic [2*IDW-1:0] slot_id = '0, tx_id;
	logic [2*BW-1:0] tx_buf;
	logic [2*DW-1:0] tx_data;
	logic [MTW-1:0] mt_now = '0, frame_mt = '0;
	logic [6:0] rx_len = '0;
	logic [15:0] rx_msg_id = '0, rx_filt_id, ut = 16'h0064;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	int failures = 0, checks = 0, cyc = 0;
	txb_if hl ();
	txb_dev i_txb_dev (.mclk(mclk), .reset(reset), .hl(hl.dev), .slot_go(slot_go), .slot_id(slot_id),
		.seg_dyn(seg_dyn), .cycle_start(cycle_start), .mt_now(mt_now), .frame_mt(frame_mt), .tx_done(tx_done),
		.tx_go(tx_go), .tx_buf(tx_buf), .tx_id(tx_id), .tx_data(tx_data), .rx_valid(rx_valid), .rx_len(rx_len),
		.rx_msg_id(rx_msg_id), .rx_filt_valid(rx_filt_valid), .rx_filt_id(rx_filt_id));
	txb_host i_txb_host (.mclk(mclk), .reset(reset), .hl(hl.host), .ut_to_deadline(ut), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	txb_chk i_txb_chk (.mclk(mclk), .reset(reset), .cmd_valid(hl.cmd_valid), .cmd_op(hl.cmd_op),
		.cmd_buf(hl.cmd_buf), .cmd_done(hl.cmd_done), .cmd_ok(hl.cmd_ok), .stat_lock(hl.stat_lock),
		.stat_commit(hl.stat_commit), .stat_valid(hl.stat_valid), .stat_event(hl.stat_event), .irq(hl.irq));

	always #20 mclk = ~mclk;

	// a hang ends the run as a failure
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		chk({30'h0, rresp}, {30'h0, RESP_OKAY});
		rready <= 1'b0;
	endtask

	task automatic cmd(input txb_op_type op, input logic [2:0] b, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		axi_wr(REG_DATA, d, r);
		axi_wr(REG_CMD, {13'h0000, op, 13'h0000, b}, r);
		chk({30'h0, r}, {30'h0, er});
	endtask

	// configure, lock, write, commit, unlock
	task automatic prep(input logic [2:0] b, input logic [31:0] cfg);
		logic [31:0] d;
		cmd(TXB_OP_CONFIG, b, cfg, RESP_OKAY);
		cmd(TXB_OP_LOCK, b, '0, RESP_OKAY);
		chk(hl.stat_lock[b], 1'b1);
		cmd(TXB_OP_WRITE, b, 32'h0000_a500 + 32'(b), RESP_OKAY);
		cmd(TXB_OP_COMMIT, b, '0, RESP_OKAY);
		cmd(TXB_OP_UNLOCK, b, '0, RESP_OKAY);
		chk({hl.stat_commit[b], hl.stat_valid[b], hl.stat_lock[b]}, 3'b110);
		axi_rd(REG_RDATA, d);
		chk(d, 32'h0000_a500 + 32'(b));
	endtask

	// one slot pulse; eg and eb are the expected starts and buffers
	task automatic slot(input logic [1:0] m, input logic [21:0] ids, input logic [1:0] eg, input logic [5:0] eb);
		logic [1:0] g;
		@(posedge mclk);
		slot_go <= m;
		slot_id <= ids;
		@(posedge mclk);
		slot_go <= '0;
		#1;
		g = tx_go;
		chk(g, eg);
		if (eg[0])
			chk({tx_id[10:0], tx_buf[2:0], tx_data[15:0]}, {ids[10:0], eb[2:0], 16'ha500 + 16'(eb[2:0])});
		if (eg[1])
			chk({tx_id[21:11], tx_buf[5:3], tx_data[31:16]}, {ids[21:11], eb[5:3], 16'ha500 + 16'(eb[5:3])});
		@(posedge mclk);
		tx_done <= g;
		@(posedge mclk);
		tx_done <= '0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic rx(input logic [6:0] n, input logic [15:0] e);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_len <= n;
		rx_msg_id <= 16'h3c5a;
		@(posedge mclk);
		rx_valid <= 1'b0;
		#1;
		chk(rx_filt_valid, 1'b1);
		chk(rx_filt_id, e);
	endtask

	// config words: tx 31, dyn 29, chB 28, chA 27, mode 26, ien 25, id low bits
	task automatic test_static;
		logic [31:0] d;
		cmd(TXB_OP_CONFIG, 3'h1, 32'h8a00_0005, RESP_OKAY);
		axi_rd(REG_GLOBAL, d);
		chk(d[1], 1'b1);
		prep(3'h5, 32'h8a00_0005);
		axi_rd(REG_STATUS, d);
		chk(d[9:0], 10'h006);
		prep(3'h2, 32'h8a00_0005);
		ut <= 16'h0002;
		prep(3'h4, 32'h9200_0005);
		axi_rd(REG_STATUS, d);
		chk(d[9], 1'b1);
		ut <= 16'h0064;
		cmd(TXB_OP_LOCK, 3'h5, '0, RESP_SLVERR);
		cmd(TXB_OP_CONFIG, 3'h5, 32'h8a00_0007, RESP_SLVERR);
		cmd(TXB_OP_WRITE, 3'h1, '0, RESP_SLVERR);
		axi_rd(REG_STATUS, d);
		chk(d[9:8], 2'b11);
		axi_rd(REG_CMD, d);
		chk(d, 32'h0000_0001);
		slot(2'b11, {11'h005, 11'h005}, 2'b11, {3'h4, 3'h2});
		chk({hl.stat_event[2], hl.stat_commit[2], hl.stat_valid[2]}, 3'b100);
		axi_rd(REG_GLOBAL, d);
		chk(d[0], 1'b1);
		slot(2'b01, {11'h000, 11'h005}, 2'b01, {3'h0, 3'h5});
		slot(2'b01, {11'h000, 11'h005}, 2'b00, '0);
		cmd(TXB_OP_CLRFLAG, 3'h2, '0, RESP_OKAY);
		cmd(TXB_OP_CLRFLAG, 3'h4, '0, RESP_OKAY);
		cmd(TXB_OP_CLRFLAG, 3'h5, '0, RESP_OKAY);
		axi_rd(REG_GLOBAL, d);
		chk(d[0], 1'b0);
	endtask

	task automatic test_dyn;
		seg_dyn <= 1'b1;
		cmd(TXB_OP_CONFIG, 3'h3, 32'ha800_0003, RESP_SLVERR);
		prep(3'h6, 32'ha800_0014);
		prep(3'h7, 32'ha800_0014);
		prep(3'h0, 32'hb400_0015);
		slot(2'b11, {11'h015, 11'h014}, 2'b11, {3'h0, 3'h6});
		chk({hl.stat_event[0], hl.stat_commit[0], hl.stat_valid[0]}, 3'b101);
		slot(2'b01, {11'h000, 11'h014}, 2'b00, '0);
		@(posedge mclk);
		cycle_start <= 1'b1;
		@(posedge mclk);
		cycle_start <= 1'b0;
		slot(2'b01, {11'h000, 11'h014}, 2'b01, {3'h0, 3'h7});
		prep(3'h3, 32'hb800_0016);
		cmd(TXB_OP_GLOBAL, 3'h0, 32'h0000_0064, RESP_OKAY);
		mt_now <= 16'h005a;
		frame_mt <= 16'h0014;
		slot(2'b11, {11'h016, 11'h016}, 2'b00, '0);
		mt_now <= 16'h0050;
		slot(2'b11, {11'h016, 11'h016}, 2'b11, {3'h3, 3'h3});
	endtask

	initial
	begin
		logic [31:0] d;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		axi_rd(REG_GLOBAL, d);
		chk(d, 32'h0000_0000);
		cmd(TXB_OP_GLOBAL, 3'h0, 32'h8000_0009, RESP_OKAY);
		axi_rd(REG_GLOBAL, d);
		chk(d[1], 1'b1);
		cmd(TXB_OP_GLOBAL, 3'h0, 32'h8000_0000, RESP_OKAY);
		axi_rd(REG_GLOBAL, d);
		chk(d[1], 1'b0);
		rx(7'h00, MSGID_DEFAULT);
		rx(MSGID_MIN_LEN, 16'h3c5a);
		test_static();
		test_dyn();
		report_and_stop();
	end
endmodule // tb_tx_buffer_selection_arbiter
